// *** design/fcs_unit.v ***
// flash command and status unit, register side
// assumes a plain strobe register port and one clock
//
// Strobed register access was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "fcs_consts.vh"
module fcs_unit #(
    parameter PAGE_W = 8,
    parameter PAGES_PER_REGION = 32,
    parameter PAGE_CYCLES = (`FCS_PAGE_TIME_NS / `FCS_CLK_NS),
    parameter ERASE_CYCLES = (`FCS_ERASE_TIME_NS / `FCS_CLK_NS),
    parameter NV_CYCLES = (`FCS_PAGE_TIME_NS / `FCS_CLK_NS)
) (
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_ce,
    input wire [7:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata_ff,
    output wire o_irq,
    output reg o_prog_ff,
    output reg [PAGE_W-1:0] o_prog_page_ff,
    output reg o_erase_ff
);
    localparam TW = 24;
    localparam ST_IDLE = 2'd0;
    localparam ST_RUN = 2'd1;
    localparam ST_LOCKSTEP = 2'd2;
    ////////////////////////////////////////////////////////////////////
    // functions
    function [2:0] fcs_region;
        input [PAGE_W-1:0] pg;
        reg [31:0] quot;
        begin
            quot = pg / PAGES_PER_REGION;
            fcs_region = quot[2:0];
        end
    endfunction
    function fcs_valid;
        input [3:0] c;
        begin
            fcs_valid = (c == `FCS_CMD_WP) || (c == `FCS_CMD_LOCK) ||
                (c == `FCS_CMD_WPL) || (c == `FCS_CMD_UNLOCK) ||
                (c == `FCS_CMD_ERASE) || (c == `FCS_CMD_SETGP) ||
                (c == `FCS_CMD_CLRGP) || (c == `FCS_CMD_SECURE);
        end
    endfunction
    ////////////////////////////////////////////////////////////////////
    // state
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [3:0] cmd_ff;
    reg [PAGE_W-1:0] page_ff;
    reg [31:0] mode_ff;
    reg locked_region_error_flag_ff;
    reg bad_command_error_flag_ff;
    reg sec_ff;
    reg [1:0] gp_ff;
    reg [7:0] locks_ff;
    reg [TW-1:0] tcycles;
    reg tstart;
    wire tbusy;
    wire tdone;
    wire [2:0] irq_stat;
    wire [2:0] irq_evt;
    reg [2:0] irq_clr;
    reg [2:0] irq_en_ff;
    wire wr_mode = i_wr && (i_addr == `FCS_ADDR_MODE);
    wire wr_cmd = i_wr && (i_addr == `FCS_ADDR_CMD);
    wire rd_stat = i_rd && (i_addr == `FCS_ADDR_STAT);
    wire [3:0] w_cmd = i_wdata[3:0];
    wire [PAGE_W-1:0] w_page = i_wdata[`FCS_PAGE_LSB +: PAGE_W];
    wire key_ok = (i_wdata[`FCS_KEY_LSB +: 8] == `FCS_KEY);
    wire idle = (state_ff == ST_IDLE);
    wire w_valid = fcs_valid(w_cmd);
    wire [2:0] w_region = fcs_region(w_page);
    wire w_prog = (w_cmd == `FCS_CMD_WP) || (w_cmd == `FCS_CMD_WPL);
    wire lock_hit = w_prog && locks_ff[w_region];
    wire erase_hit = (w_cmd == `FCS_CMD_ERASE) && (locks_ff != 8'h00);
    wire accept = wr_cmd && idle && key_ok && w_valid && !lock_hit &&
        !erase_hit;
    wire bad_cmd = wr_cmd && (!key_ok || (!w_valid &&
        (w_cmd != `FCS_CMD_NOP)));
    wire lock_err = wr_cmd && key_ok && (lock_hit || erase_hit);
    wire rdy = idle;
    wire [31:0] stat_word = {8'h00, locks_ff, 6'h00, gp_ff, 3'h0, sec_ff,
        bad_command_error_flag_ff, locked_region_error_flag_ff, 1'b0, rdy};
    reg rdy_q_ff;
    ////////////////////////////////////////////////////////////////////
    // operation sequencer
    always @* begin
        nxt_state = state_ff;
        tstart = 1'b0;
        tcycles = NV_CYCLES[TW-1:0];
        case (state_ff)
            ST_IDLE: begin
                if (accept) begin
                    nxt_state = ST_RUN;
                    tstart = 1'b1;
                    if (w_prog) begin
                        tcycles = PAGE_CYCLES[TW-1:0];
                    end else if (w_cmd == `FCS_CMD_ERASE) begin
                        tcycles = ERASE_CYCLES[TW-1:0];
                    end
                end
            end
            ST_RUN: begin
                if (tdone) begin
                    if (cmd_ff == `FCS_CMD_WPL) begin
                        nxt_state = ST_LOCKSTEP;
                        tstart = 1'b1;
                    end else begin
                        nxt_state = ST_IDLE;
                    end
                end
            end
            ST_LOCKSTEP: begin
                if (tdone) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end
    fcs_timer #(
        .W(TW)
    ) u_timer (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_start(tstart),
        .i_cycles(tcycles),
        .o_busy(tbusy),
        .o_done_ff(tdone)
    );
    ////////////////////////////////////////////////////////////////////
    // registers and nonvolatile image
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_ff <= ST_IDLE;
            cmd_ff <= 4'h0;
            page_ff <= {PAGE_W{1'b0}};
            mode_ff <= `FCS_MODE_RESET;
            locked_region_error_flag_ff <= 1'b0;
            bad_command_error_flag_ff <= 1'b0;
            sec_ff <= 1'b0;
            gp_ff <= 2'b00;
            locks_ff <= 8'h00;
            o_rdata_ff <= 32'h00000000;
            o_prog_ff <= 1'b0;
            o_prog_page_ff <= {PAGE_W{1'b0}};
            o_erase_ff <= 1'b0;
            irq_en_ff <= 3'b000;
            rdy_q_ff <= 1'b1;
        end else if (i_ce) begin
            state_ff <= nxt_state;
            rdy_q_ff <= rdy;
            if (wr_mode) begin
                mode_ff <= i_wdata;
            end
            if (i_wr && (i_addr == `FCS_ADDR_IRQ_EN)) begin
                irq_en_ff <= i_wdata[2:0];
            end
            if (accept) begin
                cmd_ff <= w_cmd;
                page_ff <= w_page;
            end
            if (lock_err) begin
                locked_region_error_flag_ff <= 1'b1;
            end else if (rd_stat) begin
                locked_region_error_flag_ff <= 1'b0;
            end
            if (bad_cmd) begin
                bad_command_error_flag_ff <= 1'b1;
            end else if (accept || (wr_cmd && w_cmd == `FCS_CMD_NOP)) begin
                bad_command_error_flag_ff <= 1'b0;
            end
            o_prog_ff <= (state_ff == ST_RUN) && ((cmd_ff == `FCS_CMD_WP) ||
                (cmd_ff == `FCS_CMD_WPL));
            o_prog_page_ff <= page_ff;
            o_erase_ff <= (state_ff == ST_RUN) && (cmd_ff == `FCS_CMD_ERASE);
            if (tdone && state_ff == ST_RUN) begin
                case (cmd_ff)
                    `FCS_CMD_LOCK: begin
                        locks_ff[fcs_region(page_ff)] <= 1'b1;
                    end
                    `FCS_CMD_UNLOCK: begin
                        locks_ff[fcs_region(page_ff)] <= 1'b0;
                    end
                    `FCS_CMD_SETGP: begin
                        gp_ff[page_ff[0]] <= 1'b1;
                    end
                    `FCS_CMD_CLRGP: begin
                        gp_ff[page_ff[0]] <= 1'b0;
                    end
                    `FCS_CMD_SECURE: begin
                        sec_ff <= 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
            if (tdone && state_ff == ST_LOCKSTEP) begin
                locks_ff[fcs_region(page_ff)] <= 1'b1;
            end
            if (rd_stat) begin
                o_rdata_ff <= stat_word;
            end else if (i_rd && i_addr == `FCS_ADDR_MODE) begin
                o_rdata_ff <= mode_ff;
            end else if (i_rd && i_addr == `FCS_ADDR_IRQ_STAT) begin
                o_rdata_ff <= {29'h00000000, irq_stat};
            end else if (i_rd && i_addr == `FCS_ADDR_IRQ_EN) begin
                o_rdata_ff <= {29'h00000000, irq_en_ff};
            end else if (i_rd) begin
                o_rdata_ff <= 32'h00000000;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////
    // interrupt
    always @* begin
        irq_clr = 3'b000;
        if (i_wr && (i_addr == `FCS_ADDR_IRQ_CLR)) begin
            irq_clr = i_wdata[2:0];
        end
    end
    assign irq_evt = {bad_cmd, lock_err, rdy && !rdy_q_ff};
    fcs_irq #(
        .N(3)
    ) u_irq (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_evt(irq_evt),
        .i_clr(irq_clr),
        .i_en(irq_en_ff & {mode_ff[`FCS_BIT_BAD_COMMAND_ERROR_FLAG], mode_ff[`FCS_BIT_LOCKED_REGION_ERROR_FLAG],
            mode_ff[`FCS_BIT_RDY]}),
        .o_stat_ff(irq_stat),
        .o_irq(o_irq)
    );
endmodule // fcs_unit
`default_nettype wire

// *** pkg/fcs_consts.vh ***
// constants of the flash command and status unit
// assumes a plain register port with reads answered one cycle later
//
// What this block does
// - write page commands program page; lock variant locks
// - lock commands pick region from page number
// - general bit commands use page field index
// - unused page field bits are ignored
// - command runs only with matching key
// - wrong key discards write, starts nothing
// - ready flag low while busy, high otherwise
// - lock error set on locked target, read clears
// - program error on bad code or key
// - security bit shown in status bit four
// - general bits shown in status eight, nine
// - region locks shown in status sixteen to 23
// - four bit command field decode table
// - reserved code raises program error, no-op not
// - interrupts gated by mode register enables
`ifndef FCS_CONSTS_VH
`define FCS_CONSTS_VH
`define FCS_ADDR_MODE 8'h60
`define FCS_ADDR_CMD 8'h64
`define FCS_ADDR_STAT 8'h68
`define FCS_ADDR_IRQ_STAT 8'h70
`define FCS_ADDR_IRQ_EN 8'h74
`define FCS_ADDR_IRQ_CLR 8'h78
`define FCS_KEY 8'h5A
`define FCS_KEY_LSB 24
`define FCS_PAGE_LSB 8
`define FCS_CMD_NOP 4'h0
`define FCS_CMD_WP 4'h1
`define FCS_CMD_LOCK 4'h2
`define FCS_CMD_WPL 4'h3
`define FCS_CMD_UNLOCK 4'h4
`define FCS_CMD_ERASE 4'h8
`define FCS_CMD_SETGP 4'hB
`define FCS_CMD_CLRGP 4'hD
`define FCS_CMD_SECURE 4'hF
`define FCS_BIT_RDY 0
`define FCS_BIT_LOCKED_REGION_ERROR_FLAG 2
`define FCS_BIT_BAD_COMMAND_ERROR_FLAG 3
`define FCS_BIT_SEC 4
`define FCS_BIT_GP0 8
`define FCS_BIT_LOCK0 16
`define FCS_MODE_RESET 32'h00000000
`define FCS_PAGE_TIME_NS 4000000
`define FCS_ERASE_TIME_NS 10000000
`define FCS_CLK_NS 5
`endif

// *** design/fcs_timer.v ***
// busy timer of the flash command and status unit
// assumes start is a one cycle pulse while idle
`timescale 1ns/10ps
`default_nettype none
module fcs_timer #(
    parameter W = 24
) (
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_ce,
    input wire i_start,
    input wire [W-1:0] i_cycles,
    output wire o_busy,
    output reg o_done_ff
);
    reg [W-1:0] cnt_ff;
    wire [W-1:0] nxt_cnt;
    assign o_busy = (cnt_ff != {W{1'b0}});
    assign nxt_cnt = i_start ? i_cycles :
        (o_busy ? cnt_ff - {{(W-1){1'b0}}, 1'b1} : cnt_ff);
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_ff <= {W{1'b0}};
            o_done_ff <= 1'b0;
        end else if (i_ce) begin
            cnt_ff <= nxt_cnt;
            o_done_ff <= (cnt_ff == {{(W-1){1'b0}}, 1'b1}) && !i_start;
        end
    end
endmodule // fcs_timer
`default_nettype wire

// *** design/fcs_irq.v ***
// sticky event flags with enable and write-one clear
// assumes event pulses and clear word are one cycle
`timescale 1ns/10ps
`default_nettype none
module fcs_irq #(
    parameter N = 3
) (
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_ce,
    input wire [N-1:0] i_evt,
    input wire [N-1:0] i_clr,
    input wire [N-1:0] i_en,
    output reg [N-1:0] o_stat_ff,
    output wire o_irq
);
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : g_bit
            always @(posedge i_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    o_stat_ff[g] <= 1'b0;
                end else if (i_ce) begin
                    if (i_evt[g]) begin
                        o_stat_ff[g] <= 1'b1;
                    end else if (i_clr[g]) begin
                        o_stat_ff[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate
    assign o_irq = |(o_stat_ff & i_en);
endmodule // fcs_irq
`default_nettype wire

// *** test/fcs_unit_sva.sv ***
// assertions for the flash command and status unit
// assumes binding to fcs_unit, one clock, async reset
`timescale 1ns/10ps
`default_nettype none
`include "fcs_consts.vh"
module fcs_unit_chk #(
    parameter PAGE_W = 8
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata_ff,
    input wire logic o_irq,
    input wire logic o_prog_ff,
    input wire logic [PAGE_W-1:0] o_prog_page_ff,
    input wire logic o_erase_ff
);
    logic [3:0] md_ff;
    logic [2:0] en_ff;
    wire logic cmd_w = i_ce && i_wr && i_addr == `FCS_ADDR_CMD;
    wire logic key_ok = i_wdata[31:24] == `FCS_KEY;
    wire logic [3:0] code = i_wdata[3:0];
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    ////////////////////////////////////////////////////////////////////////
    // shadow of mode and interrupt enable bits
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            md_ff <= 4'h0;
            en_ff <= 3'h0;
        end else if (i_ce && i_wr) begin
            if (i_addr == `FCS_ADDR_MODE)
                md_ff <= i_wdata[3:0];
            if (i_addr == `FCS_ADDR_IRQ_EN)
                en_ff <= i_wdata[2:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_prog_cause;
        $rose(o_prog_ff) |-> $past(cmd_w, 2) && $past(key_ok, 2) &&
            $past(code, 2) inside {`FCS_CMD_WP, `FCS_CMD_WPL};
    endproperty
    a_prog_cause: assert property (p_prog_cause)
        else $error("program started without keyed command");
    property p_erase_cause;
        $rose(o_erase_ff) |-> $past(cmd_w, 2) && $past(key_ok, 2) &&
            $past(code, 2) == `FCS_CMD_ERASE;
    endproperty
    a_erase_cause: assert property (p_erase_cause)
        else $error("erase started without keyed command");
    property p_page;
        $rose(o_prog_ff) |->
            o_prog_page_ff == $past(i_wdata[`FCS_PAGE_LSB +: PAGE_W], 2);
    endproperty
    a_page: assert property (p_page)
        else $error("wrong page programmed");
    property p_page_hold;
        o_prog_ff && $past(o_prog_ff) |-> $stable(o_prog_page_ff);
    endproperty
    a_page_hold: assert property (p_page_hold)
        else $error("page changed while busy");
    property p_excl;
        !(o_prog_ff && o_erase_ff);
    endproperty
    a_excl: assert property (p_excl)
        else $error("program and erase at once");
    property p_unmapped;
        i_ce && i_rd && i_addr == 8'h6C |=> o_rdata_ff == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_bad_command_error_flag;
        cmd_w && !key_ok && !o_prog_ff && !o_erase_ff ##2
            i_rd && i_addr == `FCS_ADDR_STAT |=> o_rdata_ff[`FCS_BIT_BAD_COMMAND_ERROR_FLAG];
    endproperty
    a_bad_command_error_flag: assert property (p_bad_command_error_flag)
        else $error("bad key not flagged");
    property p_irq;
        o_irq |-> |({md_ff[3], md_ff[2], md_ff[0]} & en_ff);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt without enable");
endmodule // fcs_unit_chk
bind fcs_unit fcs_unit_chk #(.PAGE_W(PAGE_W)) u_chk (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata_ff(o_rdata_ff), .o_irq(o_irq),
    .o_prog_ff(o_prog_ff), .o_prog_page_ff(o_prog_page_ff),
    .o_erase_ff(o_erase_ff));
`default_nettype wire

// *** test/fcs_unit_bench.sv ***
// testbench of the flash command and status unit
// assumes short timers and the checker bound to the unit
`timescale 1ns/10ps
`default_nettype none
`include "fcs_consts.vh"
module fcs_unit_bench;
    logic i_clk, i_sys_rst, i_ce, i_wr, i_rd;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, q;
    wire [31:0] o_rdata_ff;
    wire o_irq, o_prog_ff, o_erase_ff;
    wire [7:0] o_prog_page_ff;
    int bad_count = 0;
    int n_compared = 0;
    // command word, then status after it; bit 31 set: command runs
    logic [63:0] rows [17] = '{
        64'h5A00000B_80000101, 64'h5A00010B_80000301,
        64'h5A00000D_80000201, 64'h5A012102_80020201,
        64'h5A000101_80020201, 64'h5A003F01_00020205,
        64'h5A002404_80000201, 64'h5A004503_80040201,
        64'h5A000008_00040205, 64'h5A004004_80000201,
        64'h5A00010D_80000001, 64'h5A000008_80000001,
        64'h5A000007_00000009, 64'h5A000000_00000001,
        64'h33000101_00000009, 64'h5A00000F_80000011,
        64'h5A000000_00000011};
    fcs_unit #(.PAGE_CYCLES(20), .ERASE_CYCLES(30), .NV_CYCLES(20),
        .PAGES_PER_REGION(32)) DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata_ff(o_rdata_ff), .o_irq(o_irq),
        .o_prog_ff(o_prog_ff), .o_prog_page_ff(o_prog_page_ff),
        .o_erase_ff(o_erase_ff));
    ////////////////////////////////////////////////////////////////////////
    task chk(input [31:0] got, input [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task rd(input [7:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 q = o_rdata_ff;
    endtask
    task settle;
        int n;
        n = 0;
        while (q[0] !== 1'b1 && n < 200) begin
            rd(`FCS_ADDR_STAT);
            n++;
        end
    endtask
    task irq(input e);
        repeat (2) @(posedge i_clk);
        #1 chk({31'h0, o_irq}, {31'h0, e});
    endtask
    task stop_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        stop_test();
    end
    initial begin
        {i_sys_rst, i_ce, i_wr, i_rd, i_addr, i_wdata} = {4'hC, 40'h0};
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd(`FCS_ADDR_STAT);
        chk(q, 32'h1);
        rd(`FCS_ADDR_MODE);
        chk(q, `FCS_MODE_RESET);
        for (int k = 0; k < 17; k++) begin
            wr(`FCS_ADDR_CMD, rows[k][63:32]);
            rd(`FCS_ADDR_STAT);
            chk(q & 32'h1, {31'h0, ~rows[k][31]});
            settle();
            chk(q, rows[k][31:0] & 32'h7FFFFFFF);
        end
        // second command while busy is dropped
        wr(`FCS_ADDR_CMD, 32'h5A000201);
        wr(`FCS_ADDR_CMD, 32'h5A000301);
        repeat (2) @(posedge i_clk);
        #1 chk({23'h0, o_prog_ff, o_prog_page_ff}, 32'h102);
        rd(`FCS_ADDR_STAT);
        settle();
        chk(q, 32'h11);
        wr(`FCS_ADDR_CMD, 32'h5A000008);
        repeat (2) @(posedge i_clk);
        #1 chk({31'h0, o_erase_ff}, 32'h1);
        rd(`FCS_ADDR_STAT);
        chk(q, 32'h10);
        settle();
        chk(q, 32'h11);
        wr(`FCS_ADDR_IRQ_EN, 32'h7);
        irq(1'b0);
        wr(`FCS_ADDR_MODE, 32'hD);
        irq(1'b1);
        rd(`FCS_ADDR_MODE);
        chk(q & 32'hD, 32'hD);
        rd(`FCS_ADDR_IRQ_STAT);
        chk(q, 32'h7);
        wr(`FCS_ADDR_IRQ_CLR, 32'h7);
        irq(1'b0);
        rd(`FCS_ADDR_IRQ_STAT);
        chk(q, 32'h0);
        wr(`FCS_ADDR_CMD, 32'h11000000);
        irq(1'b1);
        wr(`FCS_ADDR_MODE, 32'h0);
        irq(1'b0);
        rd(8'h6C);
        chk(q, 32'h0);
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd(`FCS_ADDR_STAT);
        chk(q, 32'h1);
        stop_test();
    end
endmodule // fcs_unit_bench
`default_nettype wire
